/* logic/rscf_sequencer.sv */
`timescale 1ns/1ps
module rscf_sequencer
  import rscf_pkg::*;
#(
  parameter int POR_WAIT_CYCLES  = RSCF_OSC_WAIT_POR,
  parameter int STOP_WAIT_CYCLES = RSCF_OSC_WAIT_STOP
) (
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Reset cause events
  input  wire logic        watchdog_overflow_in,
  input  wire logic        external_reset_req_in,
  input  wire logic        low_voltage_req_in,
  input  wire logic        cpu_detect_req_in,
  input  wire logic        clock_fail_req_in,
  input  wire logic        from_stop_mode_in,
  input  wire logic [2:0]  boot_mode_pins_in,
  // Vector fetch bus
  input  wire logic [7:0]  fetch_data_in,
  input  wire logic        fetch_ack_in,
  output logic [23:0]      fetch_addr_out,
  output logic             fetch_rd_out,
  output logic             fetch_internal_out,
  // CPU side
  output logic             cpu_reset_out,
  output logic             cpu_start_out,
  output logic [23:0]      start_addr_out,
  output logic [7:0]       mode_reg_out,
  output logic             sw_reset_pulse_out,
  output logic             pins_hiz_out
);

  typedef struct packed {
    // Sequencer control
    rscf_state_type state;
    logic           wait_go;
    logic           osc_long;
    logic           start;
    logic           hiz;
    logic [1:0]     sw_cnt;
    // Cause and detection flags
    logic           power_on_cause_flag;
    logic           watchdog_cause_flag;
    logic           external_cause_flag;
    logic           software_cause_flag;
    logic           low_voltage_flag;
    logic           detection_flag_bit;
    // Loaded by the mode fetch
    logic [7:0]     mode_reg;
    logic [23:0]    start_addr;
    // Bus slave
    logic           ack;
    logic [31:0]    rdata;
  } rscf_seq_type;

  rscf_seq_type s_reg;
  rscf_seq_type s_next;

  // Sub-block results
  logic        wait_done;
  logic        fetch_done;
  logic [23:0] fetch_vector;
  logic [7:0]  fetch_mode;

  // Bus phase and address decode
  logic        access;
  logic        complete;
  logic        hit_watchdog_control_reg;
  logic        hit_lvdc;
  logic        hit_lpmc;
  logic        hit_mode;
  logic        hit_start;
  logic        mapped;

  // Register side effects and reset causes
  logic        rd_clear;
  logic        sw_req;
  logic        lv_clr;
  logic        det_clr;
  logic        ext_set;
  logic        any_cause;

  // Read data and oscillation wait length
  logic [31:0] rd_mux;
  logic [RSCF_WAIT_WIDTH-1:0] wait_load;

  // Address match against one register offset
  function automatic logic addr_hit(input logic [7:0] addr,
                                    input logic [7:0] offset);
    addr_hit = (addr == offset);
  endfunction

  // Boot pins select internal vector mode
  function automatic logic boot_internal(input logic [2:0] pins);
    boot_internal = (pins == RSCF_BOOT_INTERNAL);
  endfunction

  // Sequencer has released the CPU
  function automatic logic state_running(input rscf_state_type st);
    state_running = (st == ST_RUN);
  endfunction

  // Oscillation stabilization timer
  assign wait_load = s_reg.osc_long ?
                     RSCF_WAIT_WIDTH'(POR_WAIT_CYCLES) :
                     RSCF_WAIT_WIDTH'(STOP_WAIT_CYCLES);

  rscf_wait_counter #(
    .WIDTH (RSCF_WAIT_WIDTH)
  ) u_wait (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .start_in (s_reg.wait_go),
    .load_in  (wait_load),
    .done_out (wait_done)
  );

  // Vector and mode byte fetch engine
  rscf_vector_fetch u_fetch (
    .clock_in         (clock_in),
    .reset_in         (reset_in),
    .start_in         (s_reg.start),
    .abort_in         (s_reg.state == ST_HOLD),
    .internal_in      (boot_internal(boot_mode_pins_in)),
    .mem_data_in      (fetch_data_in),
    .mem_ack_in       (fetch_ack_in),
    .mem_addr_out     (fetch_addr_out),
    .mem_rd_out       (fetch_rd_out),
    .mem_internal_out (fetch_internal_out),
    .done_out         (fetch_done),
    .vector_out       (fetch_vector),
    .mode_out         (fetch_mode)
  );

  // APB phase decode, answer one cycle into the access phase
  assign access    = psel_in && penable_in;
  assign complete  = access && s_reg.ack;

  // Register address decode
  assign hit_watchdog_control_reg  = addr_hit(paddr_in, RSCF_WATCHDOG_CONTROL_REG_OFFSET);
  assign hit_lvdc  = addr_hit(paddr_in, RSCF_LVDC_OFFSET);
  assign hit_lpmc  = addr_hit(paddr_in, RSCF_LPMC_OFFSET);
  assign hit_mode  = addr_hit(paddr_in, RSCF_MODE_OFFSET);
  assign hit_start = addr_hit(paddr_in, RSCF_START_OFFSET);
  assign mapped    = hit_watchdog_control_reg | hit_lvdc | hit_lpmc | hit_mode | hit_start;

  // Bus answer, slave error on an unmapped address
  assign pready_out  = complete;
  assign pslverr_out = complete && !mapped;
  assign prdata_out  = s_reg.rdata;

  // Register side effects at the completing edge
  assign rd_clear = complete && !pwrite_in && hit_watchdog_control_reg;
  assign sw_req   = complete && pwrite_in && hit_lpmc &&
                    !pwdata_in[RSCF_SWRST_BIT] &&
                    state_running(s_reg.state);

  // Low voltage register bits clear on written zeros
  assign lv_clr   = complete && pwrite_in && hit_lvdc &&
                    !pwdata_in[RSCF_LVF_BIT];
  assign det_clr  = complete && pwrite_in && hit_lvdc &&
                    !pwdata_in[RSCF_DET_BIT];

  // Causes that report through the external flag
  assign ext_set   = external_reset_req_in | low_voltage_req_in |
                     cpu_detect_req_in | clock_fail_req_in;
  assign any_cause = ext_set | watchdog_overflow_in | sw_req;

  // Read data selection, old flag values
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_watchdog_control_reg) begin
      rd_mux[RSCF_PON_BIT] = s_reg.power_on_cause_flag;
      rd_mux[RSCF_WDT_BIT] = s_reg.watchdog_cause_flag;
      rd_mux[RSCF_EXT_BIT] = s_reg.external_cause_flag;
      rd_mux[RSCF_SW_BIT]  = s_reg.software_cause_flag;
    end else if (hit_lvdc) begin
      rd_mux[RSCF_LVF_BIT] = s_reg.low_voltage_flag;
      rd_mux[RSCF_DET_BIT] = s_reg.detection_flag_bit;
    end else if (hit_lpmc) begin
      rd_mux[RSCF_SWRST_BIT] = 1'b1;
    end else if (hit_mode) begin
      rd_mux[7:0] = s_reg.mode_reg;
    end else if (hit_start) begin
      rd_mux[23:0] = s_reg.start_addr;
    end
  end

  // Next state of sequencer, flags and bus slave
  always_comb begin
    s_next         = s_reg;
    // One-cycle strobes drop unless raised below
    s_next.wait_go = 1'b0;
    s_next.start   = 1'b0;

    // Bus handshake and read capture
    if (access && !s_reg.ack) begin
      s_next.ack   = 1'b1;
      s_next.rdata = rd_mux;
    end else begin
      s_next.ack = 1'b0;
    end

    // Sticky cause flags, sets beat clears
    s_next.power_on_cause_flag = rscf_flag(s_reg.power_on_cause_flag,
                                           1'b0, rd_clear);
    s_next.watchdog_cause_flag = rscf_flag(s_reg.watchdog_cause_flag,
                                           watchdog_overflow_in,
                                           rd_clear);
    s_next.external_cause_flag = rscf_flag(s_reg.external_cause_flag,
                                           ext_set,
                                           rd_clear);
    s_next.software_cause_flag = rscf_flag(s_reg.software_cause_flag,
                                           sw_req, rd_clear);

    // Low voltage register flags, sets beat written zeros
    s_next.low_voltage_flag    = rscf_flag(s_reg.low_voltage_flag,
                                           low_voltage_req_in,
                                           lv_clr);
    s_next.detection_flag_bit  = rscf_flag(s_reg.detection_flag_bit,
                                           low_voltage_req_in |
                                           cpu_detect_req_in,
                                           det_clr);

    // Software reset pulse counter
    if (sw_req) begin
      s_next.sw_cnt = RSCF_SW_PULSE_CYCLES;
    end else if (s_reg.sw_cnt != 2'h0) begin
      s_next.sw_cnt = s_reg.sw_cnt - 2'h1;
    end

    // Reset release sequence
    if (any_cause) begin
      s_next.state = ST_HOLD;
    end else begin
      unique case (s_reg.state)
        ST_HOLD: begin
          // Leave once no cause stands and the pulse has ended
          if (s_next.sw_cnt == 2'h0) begin
            if (from_stop_mode_in) begin
              s_next.state    = ST_WAIT;
              s_next.osc_long = 1'b0;
              s_next.wait_go  = 1'b1;
            end else begin
              s_next.state = ST_FETCH;
              s_next.start = 1'b1;
            end
          end
        end
        ST_WAIT: begin
          if (wait_done) begin
            s_next.state = ST_FETCH;
            s_next.start = 1'b1;
          end
        end
        ST_FETCH: begin
          if (fetch_done) begin
            s_next.state      = ST_RUN;
            s_next.mode_reg   = fetch_mode;
            s_next.start_addr = fetch_vector;
          end
        end
        ST_RUN: begin
          s_next.state = ST_RUN;
        end
      endcase
    end

    // Pin float control
    if (state_running(s_next.state)) begin
      s_next.hiz = (s_next.mode_reg[RSCF_MODE_M1_BIT:RSCF_MODE_M0_BIT]
                    == RSCF_MODE_SINGLE_CHIP);
    end else begin
      s_next.hiz = boot_internal(boot_mode_pins_in);
    end
  end

  // State register, power-on values on reset
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      s_reg                     <= '0;
      s_reg.state               <= ST_WAIT;
      s_reg.wait_go             <= 1'b1;
      s_reg.osc_long            <= 1'b1;
      // Cause flags take their power-on values
      s_reg.power_on_cause_flag <= 1'b1;
      s_reg.external_cause_flag <= 1'b1;
      s_reg.low_voltage_flag    <= 1'b1;
      s_reg.mode_reg            <= RSCF_MODE_RESET;
      s_reg.start_addr          <= RSCF_START_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // CPU run control
  assign cpu_reset_out      = !state_running(s_reg.state);
  assign cpu_start_out      = (s_reg.state == ST_FETCH) && fetch_done;

  // Values loaded by the mode fetch
  assign start_addr_out     = s_reg.start_addr;
  assign mode_reg_out       = s_reg.mode_reg;

  // Software reset pulse and pin float
  assign sw_reset_pulse_out = (s_reg.sw_cnt != 2'h0);
  assign pins_hiz_out       = s_reg.hiz;

endmodule

/* logic/rscf_pkg.sv */
package rscf_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] RSCF_WATCHDOG_CONTROL_REG_OFFSET  = 8'h00;
  localparam logic [7:0] RSCF_LVDC_OFFSET  = 8'h04;
  localparam logic [7:0] RSCF_LPMC_OFFSET  = 8'h08;
  localparam logic [7:0] RSCF_MODE_OFFSET  = 8'h0C;
  localparam logic [7:0] RSCF_START_OFFSET = 8'h10;

  // Cause flag positions in watchdog_control_reg
  localparam int RSCF_PON_BIT = 7;
  localparam int RSCF_WDT_BIT = 6;
  localparam int RSCF_EXT_BIT = 5;
  localparam int RSCF_SW_BIT  = 4;

  // Flag positions in low_voltage_detect_control_reg
  localparam int RSCF_LVF_BIT = 7;
  localparam int RSCF_DET_BIT = 6;

  // Software reset bit in low_power_control_reg
  localparam int RSCF_SWRST_BIT = 4;

  // Mode byte bus mode field position
  localparam int RSCF_MODE_M1_BIT = 7;
  localparam int RSCF_MODE_M0_BIT = 6;
  localparam logic [1:0] RSCF_MODE_SINGLE_CHIP = 2'h0;

  // Vector and mode byte locations
  localparam logic [23:0] RSCF_VECTOR_BASE = 24'hFFFFDC;
  localparam logic [23:0] RSCF_MODE_ADDR   = 24'hFFFFDF;
  localparam logic [1:0]  RSCF_MODE_INDEX  = 2'h3;

  // Boot mode pin code for internal vector mode
  localparam logic [2:0] RSCF_BOOT_INTERNAL = 3'h3;

  // Oscillation stabilization waits, in oscillator cycles
  localparam int RSCF_OSC_WAIT_POR  = 65536;
  localparam int RSCF_OSC_WAIT_STOP = 32768;
  localparam int RSCF_WAIT_WIDTH    = 17;

  // Software reset pulse length in machine cycles
  localparam logic [1:0] RSCF_SW_PULSE_CYCLES = 2'h3;

  // Values after reset
  localparam logic [7:0]  RSCF_MODE_RESET  = 8'h00;
  localparam logic [23:0] RSCF_START_RESET = 24'h000000;

  typedef enum logic [1:0] {
    ST_HOLD  = 2'h0,
    ST_WAIT  = 2'h1,
    ST_FETCH = 2'h2,
    ST_RUN   = 2'h3
  } rscf_state_type;

  // Sticky flag update: a set in the same cycle beats the clear
  function automatic logic rscf_flag(input logic cur,
                                     input logic set,
                                     input logic clr);
    rscf_flag = set | (cur & ~clr);
  endfunction

endpackage

/* logic/rscf_wait_counter.sv */
`timescale 1ns/1ps
module rscf_wait_counter
  import rscf_pkg::*;
#(
  parameter int WIDTH = RSCF_WAIT_WIDTH
) (
  input  wire logic             clock_in,
  input  wire logic             reset_in,
  input  wire logic             start_in,
  input  wire logic [WIDTH-1:0] load_in,
  output logic                  done_out
);

  typedef struct packed {
    logic             busy;
    logic [WIDTH-1:0] count;
  } rscf_cnt_type;

  rscf_cnt_type s_reg;
  rscf_cnt_type s_next;

  // Done while the last cycle of the wait runs
  assign done_out = s_reg.busy && (s_reg.count == '0);

  // Load on start, count down, stop at zero
  always_comb begin
    s_next = s_reg;
    if (start_in) begin
      s_next.busy  = 1'b1;
      s_next.count = load_in - WIDTH'(1);
    end else if (s_reg.busy) begin
      if (s_reg.count == '0) begin
        s_next.busy = 1'b0;
      end else begin
        s_next.count = s_reg.count - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule

/* logic/rscf_vector_fetch.sv */
`timescale 1ns/1ps
module rscf_vector_fetch
  import rscf_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  input  wire logic        start_in,
  input  wire logic        abort_in,
  input  wire logic        internal_in,
  input  wire logic [7:0]  mem_data_in,
  input  wire logic        mem_ack_in,
  output logic [23:0]      mem_addr_out,
  output logic             mem_rd_out,
  output logic             mem_internal_out,
  output logic             done_out,
  output logic [23:0]      vector_out,
  output logic [7:0]       mode_out
);

  typedef struct packed {
    logic        busy;
    logic        done;
    logic        internal;
    logic [1:0]  idx;
    logic [23:0] addr;
    logic [23:0] vec;
    logic [7:0]  mode;
  } rscf_fetch_type;

  rscf_fetch_type s_reg;
  rscf_fetch_type s_next;

  assign mem_addr_out     = s_reg.addr;
  assign mem_rd_out       = s_reg.busy;
  assign mem_internal_out = s_reg.internal;
  assign done_out         = s_reg.done;
  assign vector_out       = s_reg.vec;
  assign mode_out         = s_reg.mode;

  // Four byte reads, vector low byte first, mode byte last
  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    if (abort_in) begin
      s_next.busy = 1'b0;
    end else if (start_in) begin
      s_next.busy     = 1'b1;
      s_next.idx      = 2'h0;
      s_next.addr     = RSCF_VECTOR_BASE;
      s_next.internal = internal_in;
    end else if (s_reg.busy && mem_ack_in) begin
      if (s_reg.idx == RSCF_MODE_INDEX) begin
        s_next.mode = mem_data_in;
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
      end else begin
        s_next.vec[8*s_reg.idx +: 8] = mem_data_in;
        s_next.idx  = s_reg.idx + 2'h1;
        s_next.addr = s_reg.addr + 24'h000001;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule

/* tb/rscf_sequencer_props.sv */
`timescale 1ns/1ps
module rscf_sequencer_props
  import rscf_pkg::*;
#(
  parameter int POR_WAIT_CYCLES  = RSCF_OSC_WAIT_POR,
  parameter int STOP_WAIT_CYCLES = RSCF_OSC_WAIT_STOP
) (
  input wire logic        clock_in,
  input wire logic        reset_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        watchdog_overflow_in,
  input wire logic        external_reset_req_in,
  input wire logic        low_voltage_req_in,
  input wire logic        cpu_detect_req_in,
  input wire logic        clock_fail_req_in,
  input wire logic [2:0]  boot_mode_pins_in,
  input wire logic [7:0]  fetch_data_in,
  input wire logic        fetch_ack_in,
  input wire logic [23:0] fetch_addr_out,
  input wire logic        fetch_rd_out,
  input wire logic        cpu_reset_out,
  input wire logic        cpu_start_out,
  input wire logic [7:0]  mode_reg_out,
  input wire logic        sw_reset_pulse_out,
  input wire logic        pins_hiz_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  logic        cause;
  logic [31:0] since_reg;
  logic        clean_reg;
  // Any hardware reset cause this cycle
  assign cause = watchdog_overflow_in | external_reset_req_in |
                 low_voltage_req_in | cpu_detect_req_in | clock_fail_req_in;
  // Cycles since release, and whether no cause has come since
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      since_reg <= 32'h00000000;
      clean_reg <= 1'b1;
    end else begin
      if (since_reg != 32'hFFFFFFFF) since_reg <= since_reg + 32'h1;
      if (cause) clean_reg <= 1'b0;
    end
  end
  chk_por_wait: assert property (fetch_rd_out && clean_reg |->
    since_reg >= 32'(POR_WAIT_CYCLES - 1)) else $error("fetch before wait");
  chk_fetch_base: assert property ($rose(fetch_rd_out) |->
    fetch_addr_out == RSCF_VECTOR_BASE) else $error("bad first address");
  chk_fetch_step: assert property (fetch_rd_out && fetch_ack_in &&
    fetch_addr_out != RSCF_MODE_ADDR && !cause |=> fetch_rd_out &&
    fetch_addr_out == $past(fetch_addr_out) + 24'h1)
    else $error("fetch address did not advance");
  chk_fetch_hold: assert property (fetch_rd_out && !fetch_ack_in &&
    !cause |=> fetch_rd_out && $stable(fetch_addr_out))
    else $error("fetch request dropped");
  chk_start_mode: assert property (cpu_start_out |->
    $past(fetch_ack_in) && fetch_addr_out == RSCF_MODE_ADDR)
    else $error("start too early");
  chk_mode_load: assert property (cpu_start_out |=> !cpu_reset_out &&
    mode_reg_out == $past(fetch_data_in, 2)) else $error("mode not loaded");
  chk_sw_pulse: assert property ($rose(sw_reset_pulse_out) |->
    sw_reset_pulse_out [*3] ##1 !sw_reset_pulse_out)
    else $error("software pulse length wrong");
  chk_pins_float: assert property (cpu_reset_out && $past(cpu_reset_out)
    && !$past(reset_in) && $past(boot_mode_pins_in) == RSCF_BOOT_INTERNAL
    |-> pins_hiz_out) else $error("pins not floated");
  chk_apb_wait: assert property (psel_in && penable_in &&
    !$past(penable_in) |-> !pready_out ##1 pready_out)
    else $error("ready timing wrong");
endmodule
bind rscf_sequencer rscf_sequencer_props #(
  .POR_WAIT_CYCLES (POR_WAIT_CYCLES),
  .STOP_WAIT_CYCLES(STOP_WAIT_CYCLES)
) u_props (.*);

/* tb/rscf_mem_model.sv */
`timescale 1ns/1ps
module rscf_mem_model (
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  input  wire logic        rd_in,
  input  wire logic [23:0] addr_in,
  input  wire logic [3:0]  delay_in,
  input  wire logic [7:0]  mode_in,
  output logic [7:0]       data_out,
  output logic             ack_out
);
  logic [3:0] cnt_reg;
  // Answers each byte after delay_in cycles, bus scrambled otherwise
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ack_out  <= 1'b0;
      cnt_reg  <= 4'h0;
      data_out <= 8'h5A;
    end else if (!rd_in || ack_out || cnt_reg < delay_in) begin
      ack_out  <= 1'b0;
      cnt_reg  <= (!rd_in || ack_out) ? 4'h0 : cnt_reg + 4'h1;
      data_out <= ~data_out;
    end else begin
      ack_out  <= 1'b1;
      data_out <= (addr_in[1:0] == 2'h3) ? mode_in :
                  8'h56 - 8'h22 * addr_in[7:0] + 8'h22 * 8'hDC;
    end
  end
endmodule

/* tb/rscf_sequencer_bench.sv */
`timescale 1ns/1ps
module rscf_sequencer_bench;
  import rscf_pkg::*;
  logic        clk, rst, psel, pen, pwr, pready, pslverr, ack, frd;
  logic        fint, creset, cstart, swp, hiz, stop;
  logic [4:0]  cz;
  logic [2:0]  boot;
  logic [7:0]  paddr, fdata, mode, mbyte;
  logic [3:0]  dly;
  logic [23:0] faddr, saddr;
  logic [31:0] pwdata, prdata, r;
  logic        e;
  int          fail_count, check_count;
  rscf_sequencer #(.POR_WAIT_CYCLES(16), .STOP_WAIT_CYCLES(8)) i_dut (
    .clock_in(clk), .reset_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .watchdog_overflow_in(cz[4]), .external_reset_req_in(cz[3]),
    .low_voltage_req_in(cz[2]), .cpu_detect_req_in(cz[1]),
    .clock_fail_req_in(cz[0]), .from_stop_mode_in(stop),
    .boot_mode_pins_in(boot), .fetch_data_in(fdata), .fetch_ack_in(ack),
    .fetch_addr_out(faddr), .fetch_rd_out(frd), .fetch_internal_out(fint),
    .cpu_reset_out(creset), .cpu_start_out(cstart), .start_addr_out(saddr),
    .mode_reg_out(mode), .sw_reset_pulse_out(swp), .pins_hiz_out(hiz));
  rscf_mem_model i_mem (.clock_in(clk), .reset_in(rst), .rd_in(frd),
    .addr_in(faddr), .delay_in(dly), .mode_in(mbyte), .data_out(fdata),
    .ack_out(ack));
  // Compare and report
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, waits for pready, watchdog bounds the wait
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(r, exp);
  endtask
  // Pulse causes for one cycle
  task automatic cause(input logic [4:0] m);
    @(posedge clk);
    cz <= m;
    @(posedge clk);
    cz <= 5'h00;
  endtask
  task automatic wait_run;
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while (creset !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    check(n < 300, 1'b1);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Boot after power-on, flags and read-clear
  task automatic t_boot;
    wait_run();
    check(saddr, 24'h123456);
    check(hiz, 1'b1);
    rd(RSCF_START_OFFSET, 32'h123456);
    rd(RSCF_MODE_OFFSET, 32'h0);
    apb(1'b0, RSCF_WATCHDOG_CONTROL_REG_OFFSET, 32'h0);
    check({r[7], r[5]}, 2'h3);
    rd(RSCF_WATCHDOG_CONTROL_REG_OFFSET, 32'h0);
    rd(RSCF_LVDC_OFFSET, 32'h80);
    apb(1'b1, RSCF_LVDC_OFFSET, 32'h0);
    rd(RSCF_LVDC_OFFSET, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check(e, 1'b1);
  endtask
  // Each hardware cause alone, memory latency varied
  task automatic t_causes;
    logic [7:0] ew [5];
    logic [7:0] el [5];
    ew = '{8'h40, 8'h20, 8'h20, 8'h20, 8'h20};
    el = '{8'h00, 8'h00, 8'hC0, 8'h40, 8'h00};
    for (int i = 0; i < 5; i++) begin
      dly <= 4'(i);
      mbyte <= 8'(i << 6);
      cause(5'h10 >> i);
      wait_run();
      check(mode, {24'h000000, 8'(i << 6)});
      rd(RSCF_WATCHDOG_CONTROL_REG_OFFSET, 32'(ew[i]));
      rd(RSCF_LVDC_OFFSET, 32'(el[i]));
      apb(1'b1, RSCF_LVDC_OFFSET, 32'h0);
    end
  endtask
  // Software reset, sticky and simultaneous flags
  task automatic t_multi;
    apb(1'b1, RSCF_LPMC_OFFSET, 32'h0);
    @(posedge clk);
    check(swp, 1'b1);
    wait_run();
    rd(RSCF_WATCHDOG_CONTROL_REG_OFFSET, 32'h10);
    cause(5'h10);
    wait_run();
    apb(1'b1, RSCF_LPMC_OFFSET, 32'h0);
    wait_run();
    apb(1'b1, RSCF_WATCHDOG_CONTROL_REG_OFFSET, 32'h0);
    rd(RSCF_WATCHDOG_CONTROL_REG_OFFSET, 32'h50);
    apb(1'b1, RSCF_LPMC_OFFSET, 32'h10);
    repeat (4) @(posedge clk);
    check(creset, 1'b0);
    cause(5'h18);
    wait_run();
    rd(RSCF_WATCHDOG_CONTROL_REG_OFFSET, 32'h60);
  endtask
  // Internal vector boot floats pins and reads internal ROM
  task automatic t_internal;
    int n;
    n = 0;
    boot <= RSCF_BOOT_INTERNAL;
    mbyte <= 8'h80;
    cause(5'h10);
    while (frd !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    check({fint, hiz}, 2'h3);
    wait_run();
    check(mode, 8'h80);
    boot <= 3'h0;
  endtask
  // Reset from stop mode waits for oscillation before the fetch
  task automatic t_stop;
    int n;
    n = 0;
    stop <= 1'b1;
    cause(5'h08);
    while (frd !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    check(n >= 8 && n < 300, 1'b1);
    stop <= 1'b0;
    wait_run();
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #30000;
    fail_count++;
    conclude();
  end
  initial begin
    {rst, psel, pen, pwr, stop, paddr, pwdata, cz, boot} = '0;
    rst = 1'b1;
    dly = 4'h2;
    mbyte = 8'h00;
    fail_count = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_boot();
    t_causes();
    t_multi();
    t_internal();
    t_stop();
    conclude();
  end
endmodule
